// ===== qadc_cfg.svh
// timing counts, field positions and reset values of the serial converter control
`ifndef QADC_CFG_SVH
`define QADC_CFG_SVH

`define QADC_RES_BITS 10
`define QADC_CTRL_BITS 5'h08
`define QADC_CTRL_LAST_RISE 5'h07
`define QADC_CONV_EDGES 5'h10
`define QADC_FIRST_FALL 5'h01
`define QADC_HOLD_FALL 5'h04
`define QADC_DATA_FIRST 5'h04
`define QADC_DATA_LAST 5'h0D
`define QADC_IDX_RESET 5'h00
`define QADC_ADDR_MID_POS 4
`define QADC_ADDR_LO_POS 3
`define QADC_CTRL_RESET 8'h00
`define QADC_CHAN_DEFAULT 2'h0
`define QADC_RESULT_RESET 10'h000
`define QADC_SYNC_RESET 3'h1
`define QADC_BUF_FULL 2'h2
`define QADC_BUF_ONE 2'h1
`define QADC_BUF_EMPTY 2'h0
`define QADC_REF_KHZ 25000
`define QADC_SCLK_MAX_KHZ 3200
`define QADC_SCLK_MIN_HALF_CYC ((`QADC_REF_KHZ + 2 * `QADC_SCLK_MAX_KHZ - 1) / (2 * `QADC_SCLK_MAX_KHZ))

`endif

// ===== qadc_pkg.sv
// types shared by the serial converter control
`include "qadc_cfg.svh"
package qadc_pkg;

  typedef enum logic [2:0] {
    OFF,
    ARM,
    TRACK,
    CONVERT,
    NAP
  } qadc_state_t;

  typedef struct packed {
    logic din;
    logic sclk;
    logic csN;
  } qadc_pins_t;

  typedef struct packed {
    logic [`QADC_RES_BITS-1:0] analogInputFour;
    logic [`QADC_RES_BITS-1:0] analogInputThree;
    logic [`QADC_RES_BITS-1:0] analogInputTwo;
    logic [`QADC_RES_BITS-1:0] analogInputOne;
  } qadc_samples_t;

  typedef struct packed {
    logic powered;
    logic tracking;
    logic converting;
    logic [1:0] chan;
  } qadc_status_t;

endpackage

// ===== qadc_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`include "qadc_cfg.svh"
module qadc_pin_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [2:0] pinRaw,
  output logic [2:0] pinClean
);

  localparam logic [2:0] RST_VAL = `QADC_SYNC_RESET;

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      logic stage1;
      logic stage2;
      logic stage3;
      logic clean;
      logic next_clean;
      // change taken once second and third agree
      always_comb begin
        next_clean = (stage2 == stage3) ? stage3 : clean;
      end
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          stage1 <= RST_VAL[i];
          stage2 <= RST_VAL[i];
          stage3 <= RST_VAL[i];
          clean <= RST_VAL[i];
        end else begin
          stage1 <= pinRaw[i];
          stage2 <= stage1;
          stage3 <= stage2;
          clean <= next_clean;
        end
      end
      assign pinClean[i] = clean;
    end
  endgenerate

endmodule

// ===== qadc_pair_buf.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "qadc_cfg.svh"
module qadc_pair_buf #(
  parameter int WIDTH = `QADC_RES_BITS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic [1:0] fill;
  logic [1:0] next_fill;
  logic push;
  logic pop;

  assign inReady = (fill != `QADC_BUF_FULL);
  assign outValid = (fill != `QADC_BUF_EMPTY);
  assign outData = slot0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_fill = fill;
    unique case ({push, pop})
      2'b10: begin
        if (fill == `QADC_BUF_EMPTY) begin
          next_slot0 = inData;
        end else begin
          next_slot1 = inData;
        end
        next_fill = fill + `QADC_BUF_ONE;
      end
      2'b01: begin
        next_slot0 = slot1;
        next_fill = fill - `QADC_BUF_ONE;
      end
      2'b11: begin
        next_slot0 = inData;
      end
      2'b00: begin
        next_fill = fill;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot0 <= '0;
      slot1 <= '0;
      fill <= `QADC_BUF_EMPTY;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      fill <= next_fill;
    end
  end

endmodule

// ===== qadc_serial_ctrl.sv
// serial framing and conversion sequencing of the four-channel converter
`timescale 1ns/1ns
`include "qadc_cfg.svh"
module qadc_serial_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic csN,
  input wire logic sclk,
  input wire logic din,
  input wire qadc_pkg::qadc_samples_t samples,
  output logic dout,
  output logic doutOe,
  output qadc_pkg::qadc_status_t status
);

  function automatic logic isDataSlot(input logic [4:0] idx);
    isDataSlot = (idx >= `QADC_DATA_FIRST) && (idx <= `QADC_DATA_LAST);
  endfunction

  logic [2:0] pinSync;
  qadc_pkg::qadc_pins_t pins;

  // synchronised pins, close edges may slip a clock
  // edge slip
  qadc_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pinRaw({din, sclk, csN}),
    .pinClean(pinSync)
  );
  assign pins = pinSync;

  // edge detection
  logic csPrevN;
  logic sclkPrev;
  logic next_csPrevN;
  logic next_sclkPrev;
  logic frameStart;
  logic frameEnd;
  logic sclkFall;
  logic sclkRise;
  logic intFall;

  always_comb begin
    next_csPrevN = pins.csN;
    next_sclkPrev = pins.sclk;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csPrevN <= 1'b1;
      sclkPrev <= 1'b0;
    end else begin
      csPrevN <= next_csPrevN;
      sclkPrev <= next_sclkPrev;
    end
  end

  assign frameStart = csPrevN && !pins.csN;
  assign frameEnd = !csPrevN && pins.csN;
  assign sclkFall = sclkPrev && !pins.sclk && !pins.csN;
  assign sclkRise = !sclkPrev && pins.sclk && !pins.csN;
  assign intFall = sclkFall || (frameStart && !pins.sclk);

  // conversion sequencer
  qadc_pkg::qadc_state_t state;
  qadc_pkg::qadc_state_t next_state;
  logic [4:0] fallIdx;
  logic [4:0] next_fallIdx;
  logic [4:0] riseIdx;
  logic [4:0] next_riseIdx;
  logic [7:0] ctrlShift;
  logic [7:0] next_ctrlShift;
  logic [7:0] newWord;
  logic [1:0] pendChan;
  logic [1:0] next_pendChan;
  logic [1:0] activeChan;
  logic [1:0] next_activeChan;
  logic beginConv;
  logic samplePush;
  logic [`QADC_RES_BITS-1:0] sampleCode;

  always_comb begin
    next_state = state;
    next_fallIdx = fallIdx;
    next_riseIdx = riseIdx;
    next_ctrlShift = ctrlShift;
    next_pendChan = pendChan;
    next_activeChan = activeChan;
    samplePush = 1'b0;
    newWord = {ctrlShift[6:0], pins.din};
    beginConv = intFall && ((state == qadc_pkg::OFF) || (state == qadc_pkg::ARM) || (state == qadc_pkg::NAP));
    if (pins.csN) begin
      next_state = qadc_pkg::OFF;
    end else if (beginConv) begin
      next_state = qadc_pkg::TRACK;
      next_fallIdx = `QADC_FIRST_FALL;
      next_riseIdx = `QADC_IDX_RESET;
      next_ctrlShift = `QADC_CTRL_RESET;
      next_activeChan = pendChan;
    end else begin
      unique case (state)
        qadc_pkg::OFF: begin
          next_state = qadc_pkg::ARM;
        end
        qadc_pkg::ARM: begin
          next_state = qadc_pkg::ARM;
        end
        qadc_pkg::TRACK: begin
          if (intFall) begin
            next_fallIdx = fallIdx + `QADC_FIRST_FALL;
            if ((fallIdx + `QADC_FIRST_FALL) == `QADC_HOLD_FALL) begin
              next_state = qadc_pkg::CONVERT;
              samplePush = 1'b1;
            end
          end
        end
        qadc_pkg::CONVERT: begin
          if (intFall) begin
            next_fallIdx = fallIdx + `QADC_FIRST_FALL;
            if ((fallIdx + `QADC_FIRST_FALL) == `QADC_CONV_EDGES) begin
              next_state = qadc_pkg::NAP;
            end
          end
        end
        qadc_pkg::NAP: begin
          next_state = qadc_pkg::NAP;
        end
      endcase
      if (sclkRise && (state != qadc_pkg::OFF) && (state != qadc_pkg::ARM)) begin
        if (riseIdx < `QADC_CONV_EDGES) begin
          next_riseIdx = riseIdx + `QADC_FIRST_FALL;
        end
        if (riseIdx < `QADC_CTRL_BITS) begin
          next_ctrlShift = newWord;
        end
        // address from bits four and three
        if (riseIdx == `QADC_CTRL_LAST_RISE) begin
          next_pendChan = newWord[`QADC_ADDR_MID_POS:`QADC_ADDR_LO_POS];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= qadc_pkg::OFF;
      fallIdx <= `QADC_IDX_RESET;
      riseIdx <= `QADC_IDX_RESET;
      ctrlShift <= `QADC_CTRL_RESET;
      pendChan <= `QADC_CHAN_DEFAULT;
      activeChan <= `QADC_CHAN_DEFAULT;
    end else begin
      state <= next_state;
      fallIdx <= next_fallIdx;
      riseIdx <= next_riseIdx;
      ctrlShift <= next_ctrlShift;
      pendChan <= next_pendChan;
      activeChan <= next_activeChan;
    end
  end

  always_comb begin
    unique case (activeChan)
      2'h0: sampleCode = samples.analogInputOne;
      2'h1: sampleCode = samples.analogInputTwo;
      2'h2: sampleCode = samples.analogInputThree;
      2'h3: sampleCode = samples.analogInputFour;
    endcase
  end

  // result buffer
  logic bufInReady;
  logic bufOutValid;
  logic [`QADC_RES_BITS-1:0] bufOutData;
  logic bufMsb;
  logic loadWant;
  logic next_loadWant;
  logic pop;
  logic pushAccept;

  qadc_pair_buf #(
    .WIDTH(`QADC_RES_BITS)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(samplePush),
    .inReady(bufInReady),
    .inData(sampleCode),
    .outValid(bufOutValid),
    .outReady(loadWant),
    .outData(bufOutData)
  );

  assign pushAccept = samplePush && bufInReady;
  assign pop = bufOutValid && loadWant;
  assign bufMsb = bufOutData[`QADC_RES_BITS-1];

  // output shifter
  logic [`QADC_RES_BITS-1:0] shiftReg;
  logic [`QADC_RES_BITS-1:0] next_shiftReg;
  logic next_dout;
  logic next_doutOe;

  always_comb begin
    next_shiftReg = shiftReg;
    next_loadWant = loadWant;
    if (pop) begin
      next_shiftReg = bufOutData;
      next_loadWant = 1'b0;
    end else begin
      if (pushAccept) begin
        next_loadWant = 1'b1;
      end
      if (intFall && (state == qadc_pkg::CONVERT) && isDataSlot(fallIdx) && (fallIdx != `QADC_DATA_LAST)) begin
        next_shiftReg = {shiftReg[`QADC_RES_BITS-2:0], 1'b0};
      end
    end
    if (!pins.csN && (state == qadc_pkg::CONVERT) && isDataSlot(fallIdx) && !loadWant) begin
      next_dout = shiftReg[`QADC_RES_BITS-1];
    end else begin
      next_dout = 1'b0;
    end
    next_doutOe = !pins.csN;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shiftReg <= `QADC_RESULT_RESET;
      loadWant <= 1'b0;
      dout <= 1'b0;
      doutOe <= 1'b0;
    end else begin
      shiftReg <= next_shiftReg;
      loadWant <= next_loadWant;
      dout <= next_dout;
      doutOe <= next_doutOe;
    end
  end

  assign status = '{
    powered: (state == qadc_pkg::ARM) || (state == qadc_pkg::TRACK) || (state == qadc_pkg::CONVERT),
    tracking: (state == qadc_pkg::TRACK),
    converting: (state == qadc_pkg::CONVERT),
    chan: activeChan
  };

  property p_oe_on;
    @(posedge ref_clk) disable iff (rst)
    (!csN)[*7] |-> doutOe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");

  property p_oe_off;
    @(posedge ref_clk) disable iff (rst)
    csN[*7] |-> (!doutOe && !dout && !status.powered);
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven or powered while deselected");

  property p_frame_end;
    @(posedge ref_clk) disable iff (rst)
    frameEnd |=> (state == qadc_pkg::OFF) ##1 !doutOe;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame not closed on select rise");

  property p_nap;
    @(posedge ref_clk) disable iff (rst)
    (intFall && (state == qadc_pkg::CONVERT) && (fallIdx == 5'h0F)) |=> (!status.powered && (state == qadc_pkg::NAP));
  endproperty
  a_nap: assert property (p_nap) else $error("no power-down after sixteenth fall");

  property p_track_len;
    @(posedge ref_clk) disable iff (rst)
    (intFall && (state == qadc_pkg::TRACK) && (fallIdx < 5'h03)) |=> status.tracking;
  endproperty
  a_track_len: assert property (p_track_len) else $error("track left before three clocks");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    (intFall && (state == qadc_pkg::TRACK) && (fallIdx == 5'h03)) |=> (status.converting && (fallIdx == 5'h04));
  endproperty
  a_hold: assert property (p_hold) else $error("hold not entered on fourth fall");

  property p_retrack;
    @(posedge ref_clk) disable iff (rst)
    (intFall && (state == qadc_pkg::NAP)) |=> (status.tracking && (fallIdx == 5'h01) && (status.chan == $past(pendChan)));
  endproperty
  a_retrack: assert property (p_retrack) else $error("next conversion did not start tracking");

  property p_msb;
    @(posedge ref_clk) disable iff (rst)
    pop ##1 (!pins.csN && (state == qadc_pkg::CONVERT) && (fallIdx == 5'h04)) |=> (dout == $past(bufMsb, 2));
  endproperty
  a_msb: assert property (p_msb) else $error("first result bit is not the msb");

  property p_addr;
    @(posedge ref_clk) disable iff (rst)
    (sclkRise && (riseIdx == 5'h07) && status.powered) |=> (pendChan == $past(ctrlShift[3:2]));
  endproperty
  a_addr: assert property (p_addr) else $error("channel not taken from address bits");

  property p_low_start;
    @(posedge ref_clk) disable iff (rst)
    (frameStart && !pins.sclk) |=> (status.tracking && (fallIdx == 5'h01));
  endproperty
  a_low_start: assert property (p_low_start) else $error("select fall with clock low did not track");

  property p_high_start;
    @(posedge ref_clk) disable iff (rst)
    (frameStart && pins.sclk) |=> ((state == qadc_pkg::ARM) && status.powered);
  endproperty
  a_high_start: assert property (p_high_start) else $error("clock high start did not wait for fall");

  property p_zero;
    @(posedge ref_clk) disable iff (rst)
    (state != qadc_pkg::CONVERT) |=> !dout;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero output outside result bits");

endmodule

// ===== qadc_host_model.sv
// host-side model: drives select, clock and control pins and gathers each conversion
`timescale 1ns/1ns
package qadc_tb_pkg;
  typedef struct packed {
    logic [15:0] oe;
    logic [15:0] wd;
    logic [15:0] trk;
    logic [15:0] cnv;
    logic [15:0] pwr;
    logic [1:0] chan;
  } qadc_obs_t;
endpackage

module qadc_host_model #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic dout,
  input wire logic doutOe,
  input wire qadc_pkg::qadc_status_t status,
  output logic csN,
  output logic sclk,
  output logic din
);
  qadc_tb_pkg::qadc_obs_t obs;
  qadc_tb_pkg::qadc_obs_t seen;
  int nPer = 0;
  event wordDone;

  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end

  task automatic waitCyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // select edge kept clear of clock edges
  task automatic frameStart();
    nPer = 0;
    csN = 1'b0;
    if (sclk) begin
      waitCyc(HALF);
      sclk = 1'b0;
    end
  endtask

  // control bit set before each rise
  // slow clock, ten reference cycles per half
  task automatic period(input logic bitIn, input logic last);
    waitCyc(HALF / 2);
    din = bitIn;
    waitCyc(HALF / 2);
    sclk = 1'b1;
    waitCyc(HALF);
    obs.oe = {obs.oe[14:0], doutOe};
    // released pin has no pull, reads as inverse
    obs.wd = {obs.wd[14:0], doutOe ? dout : !dout};
    obs.trk = {obs.trk[14:0], status.tracking};
    obs.cnv = {obs.cnv[14:0], status.converting};
    obs.pwr = {obs.pwr[14:0], status.powered};
    if (nPer % 16 == 0) begin
      obs.chan = status.chan;
    end
    nPer++;
    if (nPer % 16 == 0) begin
      seen = obs;
      ->wordDone;
    end
    if (!last) begin
      sclk = 1'b0;
    end
  endtask

  // frame closed after the last rise, edges apart
  task automatic frameStop(input logic idleHigh);
    waitCyc(HALF / 2);
    csN = 1'b1;
    din = ~din;
    waitCyc(HALF / 2);
    sclk = idleHigh;
    waitCyc(HALF);
  endtask
endmodule

// ===== tb_qadc_serial_ctrl.sv
// self-checking bench: host model runs frames, monitor compares each conversion
`timescale 1ns/1ns
module tb_qadc_serial_ctrl;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic csN;
  logic sclk;
  logic din;
  logic dout;
  logic doutOe;
  qadc_pkg::qadc_samples_t samples = '0;
  qadc_pkg::qadc_status_t status;
  qadc_tb_pkg::qadc_obs_t notes[$];
  int n_fail = 0;
  int checks_done = 0;
  logic [1:0] pend = 2'h0;
  logic [1:0] code = 2'h0;

  always #20 ref_clk = ~ref_clk;

  qadc_serial_ctrl dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .csN(csN),
    .sclk(sclk),
    .din(din),
    .samples(samples),
    .dout(dout),
    .doutOe(doutOe),
    .status(status)
  );

  qadc_host_model host (
    .ref_clk(ref_clk),
    .dout(dout),
    .doutOe(doutOe),
    .status(status),
    .csN(csN),
    .sclk(sclk),
    .din(din)
  );

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmpVec(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one conversion: note the expectation, then clock it through
  task automatic runConv(input logic [7:0] ctrl, input logic last);
    qadc_tb_pkg::qadc_obs_t e;
    logic [7:0] junk;
    samples = 40'({$urandom, $urandom});
    junk = 8'($urandom);
    e.oe = 16'hFFFF;
    e.wd = {3'h0, 10'(samples >> (10 * pend)), 3'h0};
    e.trk = 16'hE000;
    e.cnv = 16'h1FFE;
    e.pwr = 16'hFFFE;
    e.chan = pend;
    notes.push_back(e);
    for (int i = 0; i < 16; i++) begin
      host.period(i < 8 ? ctrl[7 - i] : junk[i - 8], last && i == 15);
    end
    // address bits apply to the next conversion
    pend = ctrl[4:3];
  endtask

  task automatic frame(input int nConv, input logic idleHigh);
    logic [7:0] ctrl;
    host.frameStart();
    for (int c = 0; c < nConv; c++) begin
      ctrl = 8'($urandom);
      ctrl[4:3] = code;
      code = code + 2'h1;
      runConv(ctrl, c == nConv - 1);
    end
    host.frameStop(idleHigh);
    cmpVec("idle pins", 16'h0000, {13'h0, doutOe, dout, status.powered});
  endtask

  // frame cut after five rises: partial word must not take effect
  task automatic abortFrame();
    host.frameStart();
    for (int i = 0; i < 5; i++) begin
      host.period(1'b1, i == 4);
    end
    host.frameStop(1'b0);
    cmpVec("abort pins", 16'h0000, {13'h0, doutOe, dout, status.powered});
  endtask

  initial begin
    qadc_tb_pkg::qadc_obs_t e;
    forever begin
      @(host.wordDone);
      if (notes.size() == 0) begin
        n_fail++;
        $display("wrong value note count expected 1 seen 0");
      end else begin
        e = notes.pop_front();
        cmpVec("enable", e.oe, host.seen.oe);
        cmpVec("result", e.wd, host.seen.wd);
        cmpVec("tracking", e.trk, host.seen.trk);
        cmpVec("converting", e.cnv, host.seen.cnv);
        cmpVec("powered", e.pwr, host.seen.pwr);
        cmpVec("channel", {14'h0, e.chan}, {14'h0, host.seen.chan});
      end
    end
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    $display("wrong value run length expected 90000 seen more");
    complete_run();
  end

  initial begin
    void'($urandom(32'hB888A288));
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    // both idle levels, one to three conversions
    for (int f = 0; f < 8; f++) begin
      frame(1 + f % 3, f[0]);
    end
    abortFrame();
    frame(2, 1'b0);
    for (int w = 0; w < 100 && notes.size() > 0; w++) begin
      @(negedge ref_clk);
    end
    if (notes.size() != 0) begin
      n_fail++;
      $display("wrong value pending notes expected 0 seen %0d", notes.size());
    end
    complete_run();
  end
endmodule
